// ---- common/fepa_regs.svh ----
// Constants for the flash erase and program sequencer: commands, limits and timings.
`ifndef FEPA_REGS_SVH
`define FEPA_REGS_SVH

`define FEPA_CLK_MHZ      100
`define FEPA_AW           15
`define FEPA_FIRST_ADDR   15'h0000
`define FEPA_LAST_ADDR    15'h7fff

`define FEPA_CMD_READ     8'h00
`define FEPA_CMD_ERASE    8'h20
`define FEPA_CMD_EVERIFY  8'ha0
`define FEPA_CMD_PROGRAM  8'h40
`define FEPA_CMD_PVERIFY  8'hc0
`define FEPA_CMD_RESET    8'hff
`define FEPA_PRE_DATA     8'h00
`define FEPA_ERASED_DATA  8'hff

`define FEPA_MAX_PULSES   5'h19
`define FEPA_MAX_ERASES   10'h3e8

// Minimum times in their own units; cycle counts round up to whole clock periods.
`define FEPA_T_PROG_NS    9500
`define FEPA_T_ERASE_US   9500
`define FEPA_T_WHGL_NS    6000
`define FEPA_T_VPH_NS     1000
`define FEPA_T_ELWL_NS    20
`define FEPA_T_WP_NS      60
`define FEPA_T_DH_NS      10
`define FEPA_T_WPH_NS     20
`define FEPA_T_ACC_NS     150
`define FEPA_CYC(t_ns)    ((((t_ns) * `FEPA_CLK_MHZ) + 999) / 1000)
`define FEPA_ERASE_CYC    (`FEPA_T_ERASE_US * `FEPA_CLK_MHZ)

`endif

// ---- common/fepa_pkg.sv ----
// Types shared by the flash erase and program sequencer.
package fepa_pkg;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h00,
    ST_VPP    = 5'h01,
    ST_PSET   = 5'h02,
    ST_PLOAD  = 5'h03,
    ST_PWAIT  = 5'h04,
    ST_PVCMD  = 5'h05,
    ST_PGL    = 5'h06,
    ST_PREAD  = 5'h07,
    ST_ESET   = 5'h08,
    ST_ESTART = 5'h09,
    ST_EWAIT  = 5'h0a,
    ST_EVCMD  = 5'h0b,
    ST_EGL    = 5'h0c,
    ST_EREAD  = 5'h0d,
    ST_ABT1   = 5'h0e,
    ST_ABT2   = 5'h0f,
    ST_FIN    = 5'h10
  } fepa_state_type;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'h0,
    PH_LEAD  = 3'h1,
    PH_PULSE = 3'h2,
    PH_HOLD  = 3'h3,
    PH_READ  = 3'h4,
    PH_GAP   = 3'h5
  } fepa_phase_type;

endpackage

// ---- common/fepa_cyc_if.sv ----
// Request and answer of one flash bus cycle between sequencer and pin driver.
`timescale 1ns/10ps
interface fepa_cyc_if;
  logic        req;
  logic        wr;
  logic [14:0] addr;
  logic [7:0]  wdata;
  logic        ack;
  logic [7:0]  rdata;

  modport master (output req, output wr, output addr, output wdata, input ack, input rdata);
  modport slave  (input req, input wr, input addr, input wdata, output ack, output rdata);
endinterface

// ---- rtl/fepa_bus_cycle.sv ----
// Pin driver that runs one timed write or read cycle on the flash bus.
`timescale 1ns/10ps
`include "fepa_regs.svh"
module fepa_bus_cycle (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  fepa_cyc_if.slave        cyc,
  output logic [14:0]      flash_addr,
  input  wire logic [7:0]  flash_dq_in,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n
);
  localparam logic [7:0] LEAD_CYC = 8'(`FEPA_CYC(`FEPA_T_ELWL_NS));
  localparam logic [7:0] WP_CYC   = 8'(`FEPA_CYC(`FEPA_T_WP_NS));
  localparam logic [7:0] DH_CYC   = 8'(`FEPA_CYC(`FEPA_T_DH_NS));
  localparam logic [7:0] WPH_CYC  = 8'(`FEPA_CYC(`FEPA_T_WPH_NS));
  // Two extra cycles cover the synchroniser on the data pins.
  localparam logic [7:0] ACC_CYC  = 8'(`FEPA_CYC(`FEPA_T_ACC_NS) + 2);

  fepa_pkg::fepa_phase_type phase;
  logic [7:0]               cnt;
  logic [7:0]               dq_meta;
  logic [7:0]               dq_sync;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
    end else begin
      dq_meta <= flash_dq_in;
      dq_sync <= dq_meta;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      phase        <= fepa_pkg::PH_IDLE;
      cnt          <= 8'h00;
      flash_addr   <= 15'h0000;
      flash_dq_out <= 8'h00;
      flash_dq_oe  <= 1'b0;
      flash_ce_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      cyc.ack      <= 1'b0;
      cyc.rdata    <= 8'h00;
    end else begin
      cyc.ack <= 1'b0;
      case (phase)
        fepa_pkg::PH_IDLE: begin
          if (cyc.req && !cyc.ack) begin
            flash_addr <= cyc.addr;
            flash_ce_n <= 1'b0;
            if (cyc.wr) begin
              flash_dq_out <= cyc.wdata;
              flash_dq_oe  <= 1'b1;
              cnt          <= LEAD_CYC - 8'h01;
              phase        <= fepa_pkg::PH_LEAD;
            end else begin
              flash_oe_n <= 1'b0;
              cnt        <= ACC_CYC - 8'h01;
              phase      <= fepa_pkg::PH_READ;
            end
          end
        end
        fepa_pkg::PH_LEAD: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            flash_we_n <= 1'b0;
            cnt        <= WP_CYC - 8'h01;
            phase      <= fepa_pkg::PH_PULSE;
          end
        end
        fepa_pkg::PH_PULSE: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            flash_we_n <= 1'b1;
            cnt        <= DH_CYC - 8'h01;
            phase      <= fepa_pkg::PH_HOLD;
          end
        end
        fepa_pkg::PH_HOLD: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            flash_dq_oe <= 1'b0;
            flash_ce_n  <= 1'b1;
            cnt         <= WPH_CYC - 8'h01;
            phase       <= fepa_pkg::PH_GAP;
          end
        end
        fepa_pkg::PH_READ: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            cyc.rdata  <= dq_sync;
            flash_oe_n <= 1'b1;
            flash_ce_n <= 1'b1;
            cnt        <= WPH_CYC - 8'h01;
            phase      <= fepa_pkg::PH_GAP;
          end
        end
        fepa_pkg::PH_GAP: begin
          cnt <= cnt - 8'h01;
          if (cnt == 8'h00) begin
            cyc.ack <= 1'b1;
            phase   <= fepa_pkg::PH_IDLE;
          end
        end
        default: phase <= fepa_pkg::PH_IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/fepa_ctrl.sv ----
// Flash erase and program sequencer that drives a command-register flash over its pins.
//
// Notes on behaviour
// - Before erasing, program every byte to 00h with the byte-program loop.
// - Write 20h to prepare erase; a second 20h write starts it.
// - Erase verify is set up by writing 0A0h with the byte address.
// - After erase-verify set-up, read once; byte is erased only if it reads 0FFh.
// - Walk erase verify up from 0000h to last address or first failure.
// - On verify failure keep the address, erase again, resume from that address.
// - Program a byte with repeated 10us pulses, each verified, until one passes.
// - At most 25 program operations per byte; then that byte has failed.
// - Write 40h to prepare programming; next write gives address and data.
// - Write 0C0h for program verify, then read once and compare with intent.
// - Wait at least 9.5us after program start before the verify command.
// - Wait at least 9.5ms after erase start before the verify command.
// - Abort by writing 0FFh twice, then a valid command such as read.
`timescale 1ns/10ps
`include "fepa_regs.svh"
module fepa_ctrl #(
  parameter int unsigned ERASE_WAIT_CYC = `FEPA_ERASE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        start_erase,
  input  wire logic        start_program,
  input  wire logic [14:0] prog_addr,
  input  wire logic [7:0]  prog_data,
  input  wire logic        abort,
  output logic             busy,
  output logic             done,
  output logic             fail,
  output logic [14:0]      fail_addr,
  output logic [14:0]      flash_addr,
  input  wire logic [7:0]  flash_dq_in,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe,
  output logic             flash_ce_n,
  output logic             flash_oe_n,
  output logic             flash_we_n,
  output logic             flash_vpp_en
);
  localparam logic [19:0] VPP_CYC   = 20'(`FEPA_CYC(`FEPA_T_VPH_NS));
  localparam logic [19:0] PROG_CYC  = 20'(`FEPA_CYC(`FEPA_T_PROG_NS));
  localparam logic [19:0] WHGL_CYC  = 20'(`FEPA_CYC(`FEPA_T_WHGL_NS));
  localparam logic [19:0] ERASE_CYC = 20'(ERASE_WAIT_CYC);

  fepa_pkg::fepa_state_type state;
  fepa_pkg::fepa_state_type next_state;
  fepa_cyc_if               cyc ();

  logic        erase_mode;
  logic        abort_pend;
  logic [14:0] addr;
  logic [7:0]  target;
  logic [4:0]  pulse_cnt;
  logic [9:0]  erase_cnt;
  logic [19:0] wait_cnt;
  logic        wait_over;
  logic        prog_ok;
  logic        erase_ok;
  logic        at_last;
  logic        pulses_spent;
  logic        erases_spent;

  assign wait_over    = (wait_cnt == 20'h00000);
  assign at_last      = (addr == `FEPA_LAST_ADDR);
  assign prog_ok      = (cyc.rdata == target);
  assign erase_ok     = (cyc.rdata == `FEPA_ERASED_DATA);
  assign pulses_spent = (pulse_cnt == `FEPA_MAX_PULSES);
  assign erases_spent = (erase_cnt == `FEPA_MAX_ERASES);

  // Bus cycle requests are a pure function of the state, addr and target.
  always_comb begin
    cyc.req   = 1'b1;
    cyc.wr    = 1'b1;
    cyc.addr  = `FEPA_FIRST_ADDR;
    cyc.wdata = `FEPA_CMD_READ;
    case (state)
      fepa_pkg::ST_PSET:   cyc.wdata = `FEPA_CMD_PROGRAM;
      fepa_pkg::ST_PLOAD: begin
        cyc.addr  = addr;
        cyc.wdata = target;
      end
      fepa_pkg::ST_PVCMD:  cyc.wdata = `FEPA_CMD_PVERIFY;
      fepa_pkg::ST_PREAD: begin
        cyc.wr   = 1'b0;
        cyc.addr = addr;
      end
      fepa_pkg::ST_ESET:   cyc.wdata = `FEPA_CMD_ERASE;
      fepa_pkg::ST_ESTART: cyc.wdata = `FEPA_CMD_ERASE;
      fepa_pkg::ST_EVCMD: begin
        cyc.addr  = addr;
        cyc.wdata = `FEPA_CMD_EVERIFY;
      end
      fepa_pkg::ST_EREAD: begin
        cyc.wr   = 1'b0;
        cyc.addr = addr;
      end
      fepa_pkg::ST_ABT1:   cyc.wdata = `FEPA_CMD_RESET;
      fepa_pkg::ST_ABT2:   cyc.wdata = `FEPA_CMD_RESET;
      fepa_pkg::ST_FIN:    cyc.wdata = `FEPA_CMD_READ;
      default:             cyc.req   = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      fepa_pkg::ST_IDLE: begin
        if (start_erase || start_program) begin
          next_state = fepa_pkg::ST_VPP;
        end
      end
      fepa_pkg::ST_VPP:    if (wait_over) next_state = fepa_pkg::ST_PSET;
      fepa_pkg::ST_PSET:   if (cyc.ack) next_state = fepa_pkg::ST_PLOAD;
      fepa_pkg::ST_PLOAD:  if (cyc.ack) next_state = fepa_pkg::ST_PWAIT;
      fepa_pkg::ST_PWAIT:  if (wait_over) next_state = fepa_pkg::ST_PVCMD;
      fepa_pkg::ST_PVCMD:  if (cyc.ack) next_state = fepa_pkg::ST_PGL;
      fepa_pkg::ST_PGL:    if (wait_over) next_state = fepa_pkg::ST_PREAD;
      fepa_pkg::ST_PREAD: begin
        if (cyc.ack) begin
          if (prog_ok) begin
            if (!erase_mode) begin
              next_state = fepa_pkg::ST_FIN;
            end else if (at_last) begin
              next_state = fepa_pkg::ST_ESET;
            end else begin
              next_state = fepa_pkg::ST_PSET;
            end
          end else if (pulses_spent) begin
            next_state = fepa_pkg::ST_FIN;
          end else begin
            next_state = fepa_pkg::ST_PSET;
          end
        end
      end
      fepa_pkg::ST_ESET:   if (cyc.ack) next_state = fepa_pkg::ST_ESTART;
      fepa_pkg::ST_ESTART: if (cyc.ack) next_state = fepa_pkg::ST_EWAIT;
      fepa_pkg::ST_EWAIT:  if (wait_over) next_state = fepa_pkg::ST_EVCMD;
      fepa_pkg::ST_EVCMD:  if (cyc.ack) next_state = fepa_pkg::ST_EGL;
      fepa_pkg::ST_EGL:    if (wait_over) next_state = fepa_pkg::ST_EREAD;
      fepa_pkg::ST_EREAD: begin
        if (cyc.ack) begin
          if (erase_ok) begin
            next_state = at_last ? fepa_pkg::ST_FIN : fepa_pkg::ST_EVCMD;
          end else begin
            next_state = erases_spent ? fepa_pkg::ST_FIN : fepa_pkg::ST_ESET;
          end
        end
      end
      fepa_pkg::ST_ABT1:   if (cyc.ack) next_state = fepa_pkg::ST_ABT2;
      fepa_pkg::ST_ABT2:   if (cyc.ack) next_state = fepa_pkg::ST_FIN;
      fepa_pkg::ST_FIN:    if (cyc.ack) next_state = fepa_pkg::ST_IDLE;
      default:             next_state = fepa_pkg::ST_IDLE;
    endcase
    // An abort never cuts a bus cycle short; it waits for the cycle to finish.
    if (abort_pend && (!cyc.req || cyc.ack) && state != fepa_pkg::ST_IDLE &&
        state != fepa_pkg::ST_ABT1 && state != fepa_pkg::ST_ABT2 &&
        state != fepa_pkg::ST_FIN) begin
      next_state = fepa_pkg::ST_ABT1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= fepa_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Each timed state loads its length on entry and leaves when the count is spent, or at once when an abort is pending.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_cnt <= 20'h00000;
    end else if (next_state != state) begin
      case (next_state)
        fepa_pkg::ST_VPP:   wait_cnt <= VPP_CYC - 20'h00001;
        fepa_pkg::ST_PWAIT: wait_cnt <= PROG_CYC - 20'h00001;
        fepa_pkg::ST_PGL:   wait_cnt <= WHGL_CYC - 20'h00001;
        fepa_pkg::ST_EWAIT: wait_cnt <= ERASE_CYC - 20'h00001;
        fepa_pkg::ST_EGL:   wait_cnt <= WHGL_CYC - 20'h00001;
        default:            wait_cnt <= 20'h00000;
      endcase
    end else if (!wait_over) begin
      wait_cnt <= wait_cnt - 20'h00001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      erase_mode <= 1'b0;
      target     <= `FEPA_PRE_DATA;
      addr       <= `FEPA_FIRST_ADDR;
    end else if (state == fepa_pkg::ST_IDLE) begin
      erase_mode <= start_erase;
      target     <= start_erase ? `FEPA_PRE_DATA : prog_data;
      addr       <= start_erase ? `FEPA_FIRST_ADDR : prog_addr;
    end else if (state == fepa_pkg::ST_PREAD && cyc.ack && prog_ok && erase_mode) begin
      addr <= at_last ? `FEPA_FIRST_ADDR : addr + 15'h0001;
    end else if (state == fepa_pkg::ST_EREAD && cyc.ack && erase_ok && !at_last) begin
      addr <= addr + 15'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pulse_cnt <= 5'h00;
    end else if (state == fepa_pkg::ST_IDLE ||
                 (state == fepa_pkg::ST_PREAD && cyc.ack && prog_ok)) begin
      pulse_cnt <= 5'h00;
    end else if (state == fepa_pkg::ST_PLOAD && cyc.ack) begin
      pulse_cnt <= pulse_cnt + 5'h01;
    end
  end

  // Bounds the erase loop, since a worn array may never verify.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      erase_cnt <= 10'h000;
    end else if (state == fepa_pkg::ST_IDLE) begin
      erase_cnt <= 10'h000;
    end else if (state == fepa_pkg::ST_ESTART && cyc.ack) begin
      erase_cnt <= erase_cnt + 10'h001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      abort_pend <= 1'b0;
    end else if (state == fepa_pkg::ST_IDLE || next_state == fepa_pkg::ST_ABT1) begin
      abort_pend <= 1'b0;
    end else if (abort) begin
      abort_pend <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fail      <= 1'b0;
      fail_addr <= 15'h0000;
    end else if (state == fepa_pkg::ST_IDLE && (start_erase || start_program)) begin
      fail <= 1'b0;
    end else if ((state == fepa_pkg::ST_PREAD && cyc.ack && !prog_ok && pulses_spent) ||
                 (state == fepa_pkg::ST_EREAD && cyc.ack && !erase_ok && erases_spent)) begin
      fail      <= 1'b1;
      fail_addr <= addr;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy         <= 1'b0;
      done         <= 1'b0;
      flash_vpp_en <= 1'b0;
    end else begin
      busy         <= (next_state != fepa_pkg::ST_IDLE);
      done         <= (state == fepa_pkg::ST_FIN && cyc.ack);
      flash_vpp_en <= (next_state != fepa_pkg::ST_IDLE);
    end
  end

  fepa_bus_cycle u_bus (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .cyc          (cyc.slave),
    .flash_addr   (flash_addr),
    .flash_dq_in  (flash_dq_in),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_ce_n   (flash_ce_n),
    .flash_oe_n   (flash_oe_n),
    .flash_we_n   (flash_we_n)
  );
endmodule

// ---- verif/fepa_ctrl_monitor.sv ----
// Checker watching the sequencer's host and flash pins.
`timescale 1ns/10ps
module fepa_ctrl_monitor #(
  parameter int unsigned ERASE_WAIT_CYC = 950000
) (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       start_erase,
  input wire logic       start_program,
  input wire logic       busy,
  input wire logic       done,
  input wire logic [7:0] flash_dq_out,
  input wire logic       flash_dq_oe,
  input wire logic       flash_ce_n,
  input wire logic       flash_oe_n,
  input wire logic       flash_we_n,
  input wire logic       flash_vpp_en
);
  int unsigned since_wh;
  int unsigned vpp_cnt;
  logic [7:0]  last_wr;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Counters saturate late, so a long idle stretch cannot wrap into a false failure.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) since_wh <= 0;
    else if (!flash_we_n) since_wh <= 0;
    else if (since_wh < 32'h7fffffff) since_wh <= since_wh + 1;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) vpp_cnt <= 0;
    else if (!flash_vpp_en) vpp_cnt <= 0;
    else if (vpp_cnt < 32'h7fffffff) vpp_cnt <= vpp_cnt + 1;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) last_wr <= 8'h00;
    else if (!flash_we_n) last_wr <= flash_dq_out;
  end

  sequence s_wr_low;
    !flash_we_n [*6];
  endsequence
  sequence s_wr_tail;
    flash_we_n && !flash_ce_n ##1 flash_ce_n && !flash_dq_oe;
  endsequence

  a_we_pulse_width: assert property ($fell(flash_we_n) |-> s_wr_low ##1 s_wr_tail)
    else $error("write strobe shape wrong");
  a_ce_lead_we: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n, 2))
    else $error("chip enable not ahead of write strobe");
  a_data_driven: assert property (!flash_we_n |-> flash_dq_oe && flash_oe_n)
    else $error("data not driven during write");
  a_read_no_fight: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
    else $error("bus contention on read");
  a_read_gap: assert property ($fell(flash_oe_n) |-> since_wh >= 600)
    else $error("read too soon after write");
  a_prog_wait: assert property ($fell(flash_we_n) && flash_dq_out == 8'hc0 |->
    since_wh >= 950)
    else $error("program verify too early");
  a_erase_wait: assert property ($fell(flash_we_n) && flash_dq_out == 8'ha0 &&
    last_wr == 8'h20 |-> since_wh >= ERASE_WAIT_CYC)
    else $error("erase verify too early");
  a_vpp_lead: assert property ($fell(flash_we_n) |-> vpp_cnt >= 100)
    else $error("supply not settled before write");
  a_busy_take: assert property (!busy && (start_erase || start_program) |=> busy)
    else $error("start not taken");
  a_done_single: assert property (done |-> !busy ##1 !done)
    else $error("done not a single idle pulse");
  a_vpp_busy: assert property (busy |-> flash_vpp_en)
    else $error("supply dropped while busy");
endmodule

bind fepa_ctrl fepa_ctrl_monitor #(.ERASE_WAIT_CYC(ERASE_WAIT_CYC)) u_mon (
  .clk_sys, .rstn, .start_erase, .start_program, .busy, .done, .flash_dq_out,
  .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_vpp_en
);

// ---- verif/fepa_flash_model.sv ----
// Behavioural command-register flash seen from its pins.
`timescale 1ns/10ps
module fepa_flash_model (
  input wire logic [14:0] addr,
  input wire logic [7:0]  din,
  input wire logic        ce_n,
  input wire logic        oe_n,
  input wire logic        we_n,
  input wire logic        vpp_en,
  input var  int          need,
  output logic [7:0]      dq
);
  logic [7:0]  mem [int];
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  last = 8'h00;
  logic [7:0]  rd;
  logic [7:0]  pd;
  logic [14:0] pa;
  logic [14:0] ea;
  logic        pw = 1'b0;
  int          pulses = 0;
  int          resets = 0;

  function automatic logic [7:0] val(input logic [14:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  always @(negedge vpp_en) cmd = 8'h00;

  always @(posedge we_n) begin
    if (!ce_n && vpp_en) begin
      if (pw) begin
        pw = 1'b0;
        if (addr !== pa) pulses = 0;
        pa = addr;
        pd = din;
        pulses++;
      end else begin
        if (din == 8'hff && cmd == 8'hff) resets++;
        if (din == 8'h20 && cmd == 8'h20) mem.delete();
        if (din == 8'ha0) ea = addr;
        // margin pass only.
        // A pulse never verified leaves the array untouched, as if stopped internally.
        if (din == 8'hc0 && pulses >= need) mem[pa] = pd;
        pw = (din == 8'h40);
        cmd = din;
      end
    end
  end

  always @* begin
    if (cmd == 8'hc0) rd = val(pa);
    else if (cmd == 8'ha0) rd = val(ea);
    else rd = val(addr);
  end

  // Released bus shows the inverse of its last value, so stale data never matches.
  always @(posedge oe_n) last = rd;
  assign dq = (!ce_n && !oe_n) ? rd : ~last;
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the flash erase and program sequencer.
`timescale 1ns/10ps
module tb_top;
  logic        clk_sys, rstn, start_erase, start_program, abort;
  logic [14:0] prog_addr, fail_addr, flash_addr;
  logic [7:0]  prog_data, dq_out, fl_dq, dq_w;
  logic        busy, done, fail, dq_oe, ce_n, oe_n, we_n, vpp;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          need = 1;

  assign dq_w = dq_oe ? dq_out : fl_dq;

  fepa_ctrl #(.ERASE_WAIT_CYC(20)) dut (
    .clk_sys(clk_sys), .rstn(rstn), .start_erase(start_erase),
    .start_program(start_program), .prog_addr(prog_addr), .prog_data(prog_data),
    .abort(abort), .busy(busy), .done(done), .fail(fail), .fail_addr(fail_addr),
    .flash_addr(flash_addr), .flash_dq_in(dq_w), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_vpp_en(vpp)
  );
  fepa_flash_model u_flash (
    .addr(flash_addr), .din(dq_w), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .vpp_en(vpp), .need(need), .dq(fl_dq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Full runs take about 50000 cycles; the ceiling leaves headroom.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic ck(input bit bad, input string m);
    total_checks++;
    if (bad) begin
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // Runs one sequence; at cycle at it aborts an erase or pokes a refused start.
  task automatic go(input logic e, input logic [14:0] a, input logic [7:0] d,
                    input int lim, input int at);
    int n;
    @(negedge clk_sys);
    start_erase = e;
    // An erase raises both starts, so the erase must win over the program request.
    start_program = 1'b1;
    prog_addr = a;
    prog_data = d;
    @(negedge clk_sys);
    start_erase = 1'b0;
    start_program = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
      abort = e && n == at;
      start_program = !e && n == at;
      if (n == at) prog_addr = 15'h0002;
    end
    ck(n >= lim, "no done");
    ck({busy, ce_n, oe_n, we_n, dq_oe} !== 5'h0e, "pins not idle at end");
  endtask

  task automatic t_prog_ok();
    need = 1;
    go(1'b0, 15'h1234, 8'h5a, 5000, 50);
    ck(u_flash.mem[15'h1234] !== 8'h5a, "byte not programmed");
    ck(u_flash.mem.exists(15'h0002), "busy start was taken");
    ck(u_flash.pulses != 1, "pulse count");
    ck(u_flash.cmd !== 8'h00, "not left in read");
    ck(fail !== 1'b0, "fail set");
    $display("test prog_ok done");
  endtask

  task automatic t_prog_retry();
    need = 3;
    go(1'b0, 15'h0100, 8'h3c, 8000, 0);
    ck(u_flash.mem[15'h0100] !== 8'h3c, "retry byte wrong");
    ck(u_flash.pulses != 3, "retry count");
    ck(fail !== 1'b0, "fail on retry");
    $display("test prog_retry done");
  endtask

  task automatic t_prog_fail();
    need = 99;
    go(1'b0, 15'h0200, 8'ha5, 60000, 0);
    ck(u_flash.pulses != 25, "pulse cap");
    ck(fail !== 1'b1, "no fail flag");
    ck(fail_addr !== 15'h0200, "fail address");
    $display("test prog_fail done");
  endtask

  task automatic t_erase_abort();
    need = 1;
    go(1'b1, 15'h0033, 8'h77, 3000, 300);
    ck(u_flash.pa !== 15'h0000, "preprogram start address");
    ck(u_flash.pd !== 8'h00, "preprogram data");
    ck(u_flash.resets != 1, "reset pair");
    ck(u_flash.cmd !== 8'h00, "no read after reset");
    ck(fail !== 1'b0, "fail not cleared by start");
    $display("test erase_abort done");
  endtask

  initial begin
    rstn = 1'b0;
    start_erase = 1'b0;
    start_program = 1'b0;
    abort = 1'b0;
    prog_addr = 15'h0000;
    prog_data = 8'h00;
    repeat (12) @(negedge clk_sys);
    ck({busy, done, fail, vpp, dq_oe, ce_n, oe_n, we_n} !== 8'h07, "reset levels");
    rstn = 1'b1;
    t_prog_ok();
    t_prog_retry();
    t_prog_fail();
    t_erase_abort();
    finish_test();
  end
endmodule
